// file: verilog/pwmim_regs.vh
// register map, field positions and timing constants of the pulse-input measurement block
`ifndef PWMIM_REGS_VH
`define PWMIM_REGS_VH

`define PWMIM_NCH          24
`define PWMIM_CLK_NS       5'h08
`define PWMIM_TICK_NS      5'h14
// one million and one thousand million, in ns per ms and ns per s
`define PWMIM_NS_PER_MS    32'h000F4240
`define PWMIM_NS_PER_S     32'h3B9ACA00
`define PWMIM_TICKS_PER_MS (`PWMIM_NS_PER_MS / {27'h0, `PWMIM_TICK_NS})
`define PWMIM_TICK_HZ      (`PWMIM_NS_PER_S / {27'h0, `PWMIM_TICK_NS})
`define PWMIM_DUTY_ONE     32'h00010000

// byte addresses of ctrl, led and time; region codes in address bits [10:8] for the slot tables
`define PWMIM_A_CTRL       11'h000
`define PWMIM_A_LED        11'h004
`define PWMIM_A_TIME       11'h008
`define PWMIM_A_THR        4'h1
`define PWMIM_A_CFG        4'h2
`define PWMIM_A_DEF        4'h3
`define PWMIM_A_RES        4'h4

// slot configuration word
`define PWMIM_F_PROC       3:0
`define PWMIM_F_TMODE      5:4
`define PWMIM_F_CHAN       12:8
`define PWMIM_F_TOUT       31:16
`define PWMIM_CFG_RST      32'h0
`define PWMIM_DEF_RST      32'h0

// threshold word: source in [1:0], user lower threshold in [27:16]
`define PWMIM_F_TSRC       1:0
`define PWMIM_F_TUSER      27:16
`define PWMIM_TSRC_A       2'h0
`define PWMIM_TSRC_B       2'h1

// indicator word: source in [6:5], channel in [4:0]
`define PWMIM_F_LCHAN      4:0
`define PWMIM_F_LSRC       6:5
`define PWMIM_LSRC_ON      2'h1
`define PWMIM_LSRC_CHAN    2'h2

// timeout modes
`define PWMIM_TM_OFF       2'h0
`define PWMIM_TM_PREDEF    2'h1
`define PWMIM_TM_INPDEP    2'h2

// measurement procedures
`define PWMIM_P_HIGH       4'h1
`define PWMIM_P_LOW        4'h2
`define PWMIM_P_ADDHI      4'h3
`define PWMIM_P_ADDLO      4'h4
`define PWMIM_P_NLOP       4'h5
`define PWMIM_P_NHIP       4'h6
`define PWMIM_P_NRISE      4'h7
`define PWMIM_P_NFALL      4'h8
`define PWMIM_P_CYCLE      4'h9
`define PWMIM_P_FREQ       4'hA
`define PWMIM_P_DUTYL      4'hB
`define PWMIM_P_DUTYH      4'hC
`define PWMIM_P_LVLHI      4'hD
`define PWMIM_P_LVLLO      4'hE

`endif

// file: verilog/pwmim_top.v
// multi-channel pulse-input measurement block with avalon-mm register access
// Contract
// - twenty-four slots, each with own procedure, timeout mode and input channel
// - edges are timestamped on a 20 ns tick
// - every procedure yields one 32-bit result word for the host
// - high/low time reports last complete pulse before the acquisition instant
// - additive modes sum active time between two host read activations
// - counting modes count pulses or edges between two read activations
// - a pulse counts when its closing edge lies inside the acquisition window
// - rising edge closes a low pulse, falling edge closes a high pulse
// - falling edge opens a low pulse, rising edge opens a high pulse
// - input active low for low-time modes, active high for high-time modes
// - timeout modes: off, predefined value, input dependent; interval in ms
// - predefined timeout mode outputs the configured default value
// - timeout when any of four edge stamps is older than now minus interval
// - input-dependent timeout gives zero for widths, sums, counts, levels
// - input-dependent timeout: cycle is elapsed time, frequency its reciprocal
// - input-dependent timeout duty is one or zero by the input level
// - cycle, low time and duty are evaluated on the rising edge of the selected input, high time on the falling edge
// - any slot may observe any input channel
// - comparator thresholds are one and two thirds of selected reference, or the user lower threshold and twice it
// - indicator led follows a selectable source, such as a channel level
// - configuration may change while measuring, with no restart
//
// Register access over Avalon-MM and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "pwmim_regs.vh"

module pwmim_slot (
    // clock, reset, enable
    input  wire        clk_i,
    input  wire        reset_i,
    input  wire        ce_i,
    // timebase
    input  wire [31:0] ts_i,
    input  wire        tick_i,
    // selected channel level and edges
    input  wire        lvl_i,
    input  wire        rise_i,
    input  wire        fall_i,
    // acquisition instant and settings
    input  wire        acq_i,
    input  wire [31:0] cfg_i,
    input  wire [31:0] def_i,
    // live result
    output reg  [31:0] result_o
);
    // settings are read every clock, so a rewrite applies at once
    wire [3:0]  proc  = cfg_i[`PWMIM_F_PROC];
    wire [1:0]  tmode = cfg_i[`PWMIM_F_TMODE];
    wire [47:0] tprod = cfg_i[`PWMIM_F_TOUT] * `PWMIM_TICKS_PER_MS;
    wire [31:0] tout  = tprod[31:0];

    // edge stamps and derived widths
    reg  [31:0] r0;
    reg  [31:0] r1;
    reg  [31:0] f0;
    reg  [31:0] f1;
    reg  [31:0] hi_w;
    reg  [31:0] lo_w;
    reg  [31:0] hi_in_per;
    reg  [31:0] per;
    // window accumulators
    reg  [31:0] sum;
    reg  [31:0] cnt;
    // serial divider
    reg  [31:0] quo;
    reg  [47:0] num;
    reg  [32:0] rem;
    reg  [31:0] den;
    reg  [5:0]  step;
    reg         busy;

    // low-time procedures see the input inverted
    wire low_mode = (proc == `PWMIM_P_LOW) || (proc == `PWMIM_P_ADDLO) ||
                    (proc == `PWMIM_P_LVLLO);
    wire active   = low_mode ? ~lvl_i : lvl_i;
    wire cnt_ev   = ((proc == `PWMIM_P_NLOP) || (proc == `PWMIM_P_NRISE)) ? rise_i :
                    ((proc == `PWMIM_P_NHIP) || (proc == `PWMIM_P_NFALL)) ? fall_i :
                    1'b0;
    wire add_ev   = tick_i & active &
                    ((proc == `PWMIM_P_ADDHI) || (proc == `PWMIM_P_ADDLO));

    // modular ages; stamps older than one counter wrap (about 85 s) are not seen as stale
    wire [31:0] elapsed = ts_i - r1;
    wire timed = (tmode != `PWMIM_TM_OFF) &&
                 (((ts_i - r0) > tout) || (elapsed > tout) ||
                  ((ts_i - f0) > tout) || ((ts_i - f1) > tout));
    wire inpdep = timed && (tmode == `PWMIM_TM_INPDEP);

    wire [32:0] trial = {rem[31:0], num[47]};

    always @(posedge clk_i) begin
        if (reset_i) begin
            r0        <= 32'h0;
            r1        <= 32'h0;
            f0        <= 32'h0;
            f1        <= 32'h0;
            hi_w      <= 32'h0;
            lo_w      <= 32'h0;
            hi_in_per <= 32'h0;
            per       <= 32'h0;
            sum       <= 32'h0;
            cnt       <= 32'h0;
            quo       <= 32'h0;
            num       <= 48'h0;
            rem       <= 33'h0;
            den       <= 32'h0;
            step      <= 6'h0;
            busy      <= 1'b0;
        end else if (ce_i) begin
            // stamps are the tick count seen at the detect edge; widths wrap past 32 bits
            if (rise_i) begin
                r0        <= r1;
                r1        <= ts_i;
                lo_w      <= ts_i - f1;
                per       <= ts_i - r1;
                hi_in_per <= f1 - r1;
            end
            if (fall_i) begin
                f0   <= f1;
                f1   <= ts_i;
                hi_w <= ts_i - r1;
            end
            // a new event in the acquire cycle opens the next window rather than being lost
            if (acq_i) begin
                sum <= {31'h0, add_ev};
                cnt <= {31'h0, cnt_ev};
            end else begin
                sum <= sum + {31'h0, add_ev};
                cnt <= cnt + {31'h0, cnt_ev};
            end
            // restoring divider, reloaded with fresh operands after each quotient
            // so frequency and duty trail a new period by fifty to ninety-nine clocks
            if (!busy) begin
                num  <= (proc == `PWMIM_P_FREQ) ? {16'h0, `PWMIM_TICK_HZ} :
                        (proc == `PWMIM_P_DUTYL) ? {lo_w, 16'h0} : {hi_in_per, 16'h0};
                den  <= (inpdep && (proc == `PWMIM_P_FREQ)) ? elapsed : per;
                rem  <= 33'h0;
                step <= 6'h0;
                busy <= 1'b1;
            end else if (step == 6'h30) begin
                quo  <= (den == 32'h0) ? 32'h0 : num[31:0];
                busy <= 1'b0;
            end else begin
                if (trial >= {1'b0, den}) begin
                    rem <= trial - {1'b0, den};
                    num <= {num[46:0], 1'b1};
                end else begin
                    rem <= trial;
                    num <= {num[46:0], 1'b0};
                end
                step <= step + 6'h1;
            end
        end
    end

    always @* begin
        result_o = 32'h0;
        // a timeout overrides the live value of every procedure
        if (timed && (tmode == `PWMIM_TM_PREDEF)) begin
            result_o = def_i;
        end else if (inpdep) begin
            case (proc)
                `PWMIM_P_CYCLE: result_o = elapsed;
                `PWMIM_P_FREQ:  result_o = quo;
                `PWMIM_P_DUTYL: result_o = lvl_i ? 32'h0 : `PWMIM_DUTY_ONE;
                `PWMIM_P_DUTYH: result_o = lvl_i ? `PWMIM_DUTY_ONE : 32'h0;
                default:        result_o = 32'h0;
            endcase
        end else begin
            case (proc)
                `PWMIM_P_HIGH:  result_o = hi_w;
                `PWMIM_P_LOW:   result_o = lo_w;
                `PWMIM_P_ADDHI: result_o = sum;
                `PWMIM_P_ADDLO: result_o = sum;
                `PWMIM_P_NLOP:  result_o = cnt;
                `PWMIM_P_NHIP:  result_o = cnt;
                `PWMIM_P_NRISE: result_o = cnt;
                `PWMIM_P_NFALL: result_o = cnt;
                `PWMIM_P_CYCLE: result_o = per;
                `PWMIM_P_FREQ:  result_o = quo;
                `PWMIM_P_DUTYL: result_o = quo;
                `PWMIM_P_DUTYH: result_o = quo;
                `PWMIM_P_LVLHI: result_o = {31'h0, active};
                `PWMIM_P_LVLLO: result_o = {31'h0, active};
                default:        result_o = 32'h0;
            endcase
        end
    end
endmodule // pwmim_slot

module pwmim_top (
    // clock, reset, enable
    input  wire          clk_i,
    input  wire          reset_i,
    input  wire          ce_i,
    // avalon-mm slave
    input  wire [10:0]   avs_address_i,
    input  wire          avs_read_i,
    input  wire          avs_write_i,
    input  wire [31:0]   avs_writedata_i,
    output reg  [31:0]   avs_readdata_o,
    output wire          avs_waitrequest_o,
    // comparator outputs and references
    input  wire [23:0]   in_i,
    input  wire [11:0]   battery_reference_a_i,
    input  wire [11:0]   battery_reference_b_i,
    // threshold and indicator drive
    output wire [287:0]  thr_lo_o,
    output wire [287:0]  thr_hi_o,
    output reg           indicator_drive_o
);
    // per-slot settings, captured results and thresholds
    reg  [31:0] cfg [0:23];
    reg  [31:0] dflt [0:23];
    reg  [31:0] thr [0:23];
    reg  [31:0] res [0:23];
    reg  [11:0] tlo [0:23];
    reg  [11:0] thi [0:23];
    wire [31:0] live [0:23];
    // indicator, edge detector and timebase
    reg  [6:0]  led_cfg;
    reg  [23:0] lvl_q;
    reg  [4:0]  phase;
    reg  [31:0] ts;
    // bus handshake and acquisition strobe
    reg         ack;
    reg         acq;
    reg  [31:0] next_rdata;

    // timebase, edge detect and bus decode
    wire [5:0]  next_phase = {1'b0, phase} + {1'b0, `PWMIM_CLK_NS};
    wire        tick       = next_phase >= {1'b0, `PWMIM_TICK_NS};
    wire [23:0] rise       = in_i & ~lvl_q;
    wire [23:0] fall       = ~in_i & lvl_q;
    wire [4:0]  idx        = avs_address_i[6:2];
    wire        idx_ok     = (avs_address_i[7] == 1'b0) && (idx < 5'h18);
    wire [3:0]  region     = {1'b0, avs_address_i[10:8]};
    wire        wr_go      = avs_write_i & ack;

    // one wait cycle for every access; the answer lands at the second edge
    assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack;

    always @(posedge clk_i) begin
        if (reset_i) begin
            phase <= 5'h0;
            ts    <= 32'h0;
            lvl_q <= 24'h0;
        end else if (ce_i) begin
            // 8 ns clock into 20 ns ticks by a phase accumulator
            phase <= tick ? (next_phase[4:0] - `PWMIM_TICK_NS) : next_phase[4:0];
            ts    <= ts + {31'h0, tick};
            lvl_q <= in_i;
        end
    end

    genvar g;
    generate
        for (g = 0; g < `PWMIM_NCH; g = g + 1) begin : g_ch
            wire [4:0]  ch = cfg[g][`PWMIM_F_CHAN];
            wire [1:0]  src = thr[g][`PWMIM_F_TSRC];
            wire [11:0] ref_v = (src == `PWMIM_TSRC_A) ? battery_reference_a_i :
                                battery_reference_b_i;
            wire [12:0] ref_x2 = {ref_v, 1'b0};
            wire [12:0] hi_b = ref_x2 / 13'h3;
            wire [12:0] usr_x2 = {thr[g][`PWMIM_F_TUSER], 1'b0};
            // an out-of-range channel reads as a steady low
            wire        ch_ok = ch < 5'h18;

            // a channel change shows no false edge, as edges are found per channel; the slot keeps running
            pwmim_slot u_slot (
                .clk_i    (clk_i),
                .reset_i  (reset_i),
                .ce_i     (ce_i),
                .ts_i     (ts),
                .tick_i   (tick),
                .lvl_i    (ch_ok ? in_i[ch] : 1'b0),
                .rise_i   (ch_ok ? rise[ch] : 1'b0),
                .fall_i   (ch_ok ? fall[ch] : 1'b0),
                .acq_i    (acq),
                .cfg_i    (cfg[g]),
                .def_i    (dflt[g]),
                .result_o (live[g])
            );

            always @(posedge clk_i) begin
                if (reset_i) begin
                    tlo[g] <= 12'h0;
                    thi[g] <= 12'h0;
                    res[g] <= 32'h0;
                end else if (ce_i) begin
                    // thresholds trail a reference change by one clock
                    if (src[1]) begin
                        tlo[g] <= thr[g][`PWMIM_F_TUSER];
                        thi[g] <= usr_x2[11:0];
                    end else begin
                        tlo[g] <= ref_v / 12'h3;
                        thi[g] <= hi_b[11:0];
                    end
                    // all slots copy at one edge, so a read never mixes two windows
                    if (acq) begin
                        res[g] <= live[g];
                    end
                end
            end
            assign thr_lo_o[g*12 +: 12] = tlo[g];
            assign thr_hi_o[g*12 +: 12] = thi[g];
        end
    endgenerate

    always @* begin
        next_rdata = 32'h0;
        if (avs_address_i == `PWMIM_A_LED) begin
            next_rdata = {25'h0, led_cfg};
        end else if (avs_address_i == `PWMIM_A_TIME) begin
            next_rdata = ts;
        end else if (idx_ok) begin
            case (region)
                `PWMIM_A_THR: next_rdata = thr[idx];
                `PWMIM_A_CFG: next_rdata = cfg[idx];
                `PWMIM_A_DEF: next_rdata = dflt[idx];
                `PWMIM_A_RES: next_rdata = res[idx];
                default:      next_rdata = 32'h0;
            endcase
        end
    end

    integer i;
    always @(posedge clk_i) begin
        if (reset_i) begin
            ack               <= 1'b0;
            acq               <= 1'b0;
            avs_readdata_o    <= 32'h0;
            led_cfg           <= 7'h0;
            indicator_drive_o <= 1'b0;
            for (i = 0; i < `PWMIM_NCH; i = i + 1) begin
                cfg[i]  <= `PWMIM_CFG_RST;
                dflt[i] <= `PWMIM_DEF_RST;
                thr[i]  <= 32'h0;
            end
        end else if (ce_i) begin
            ack <= (avs_read_i | avs_write_i) & ~ack;
            acq <= wr_go && (avs_address_i == `PWMIM_A_CTRL) && avs_writedata_i[0];
            // a read copies the word at its first edge and holds it until the next read
            if (avs_read_i & ~ack) begin
                avs_readdata_o <= next_rdata;
            end
            // writes land at the answer edge, while waitrequest is low
            if (wr_go && (avs_address_i == `PWMIM_A_LED)) begin
                led_cfg <= avs_writedata_i[6:0];
            end
            if (wr_go && idx_ok) begin
                case (region)
                    `PWMIM_A_THR: thr[idx]  <= avs_writedata_i;
                    `PWMIM_A_CFG: cfg[idx]  <= avs_writedata_i;
                    `PWMIM_A_DEF: dflt[idx] <= avs_writedata_i;
                    default: ;
                endcase
            end
            // the lamp trails its channel by one clock, far below what the eye sees
            case (led_cfg[`PWMIM_F_LSRC])
                `PWMIM_LSRC_ON:   indicator_drive_o <= 1'b1;
                `PWMIM_LSRC_CHAN: indicator_drive_o <= (led_cfg[`PWMIM_F_LCHAN] < 5'h18) ?
                                                       in_i[led_cfg[`PWMIM_F_LCHAN]] : 1'b0;
                default:          indicator_drive_o <= 1'b0;
            endcase
        end
    end
endmodule // pwmim_top

// file: verif/pim_chk.sv
// assertion checker bound to the pulse-input measurement top
`timescale 1ns/1ps
module pim_chk (
    // clock and reset
    input logic         clk_i,
    input logic         reset_i,
    // register bus
    input logic [10:0]  avs_address_i,
    input logic         avs_read_i,
    input logic         avs_write_i,
    input logic [31:0]  avs_writedata_i,
    input logic [31:0]  avs_readdata_o,
    input logic         avs_waitrequest_o,
    // inputs, thresholds and indicator
    input logic [23:0]  in_i,
    input logic [11:0]  battery_reference_a_i,
    input logic [287:0] thr_lo_o,
    input logic [287:0] thr_hi_o,
    input logic         indicator_drive_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);

    // mirror of the indicator source, taken when a write completes
    logic [1:0] led_src;
    logic [4:0] led_ch;
    always @(posedge clk_i) begin
        if (reset_i) begin
            led_src <= 2'h0;
            led_ch  <= 5'h0;
        end else if (avs_write_i && !avs_waitrequest_o && avs_address_i == 11'h004) begin
            led_src <= avs_writedata_i[6:5];
            led_ch  <= avs_writedata_i[4:0];
        end
    end

    AST_WAIT_TAKE: assert property (
        (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
        else $error("request not answered in the following cycle");
    AST_WAIT_NEXT: assert property (
        !avs_waitrequest_o |=> avs_waitrequest_o == (avs_read_i || avs_write_i))
        else $error("waitrequest does not follow a fresh request");
    AST_RD_STANDS: assert property (
        !(avs_read_i && avs_waitrequest_o) |=> $stable(avs_readdata_o))
        else $error("read data changed without a new read");
    AST_RD_ZERO: assert property (
        avs_read_i && !avs_waitrequest_o
        && (avs_address_i[10:2] == 9'h0 || avs_address_i[10:8] > 3'h4)
        |-> avs_readdata_o == 32'h0)
        else $error("control or unmapped read is not zero");
    AST_RESET_OUT: assert property (@(posedge clk_i) disable iff (1'b0)
        reset_i |=> avs_readdata_o == 32'h0 && !indicator_drive_o && thr_lo_o == 288'h0)
        else $error("outputs not cleared by reset");
    AST_THR_RESET_A: assert property (
        $fell(reset_i) |-> ##2 thr_lo_o[11:0] == battery_reference_a_i / 12'h3)
        else $error("threshold after reset not taken from reference a");
    AST_THR_RATIO: assert property (
        thr_hi_o[83:72] - {thr_lo_o[82:72], 1'b0} <= 12'h1)
        else $error("upper threshold is not twice the lower one");
    AST_LED_CHAN: assert property (
        (led_src == 2'h2 && $stable(led_ch) && $stable(in_i[led_ch]))[*3]
        |-> indicator_drive_o == in_i[led_ch])
        else $error("indicator does not follow the selected channel");
    AST_LED_ON: assert property (
        (led_src == 2'h1)[*3] |-> indicator_drive_o)
        else $error("indicator not lit for source on");
endmodule // pim_chk

bind pwmim_top pim_chk chk (
    .clk_i, .reset_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
    .avs_readdata_o, .avs_waitrequest_o, .in_i, .battery_reference_a_i,
    .thr_lo_o, .thr_hi_o, .indicator_drive_o
);

// file: verif/pim_host.sv
// host processor model: bus master that sets up slots and fetches results
`timescale 1ns/1ps
module pim_host (
    // clock
    input  logic        clk_i,
    // bus master side
    input  logic        waitrequest_i,
    input  logic [31:0] readdata_i,
    output logic [10:0] address_o,
    output logic        read_o,
    output logic        write_o,
    output logic [31:0] writedata_o
);
    initial begin
        address_o   = 11'h7FF;
        read_o      = 1'b0;
        write_o     = 1'b0;
        writedata_o = 32'hFFFFFFFF;
    end

    // settings may be rewritten at any time while measuring runs
    task automatic xfer(input logic wr, input logic [10:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        @(posedge clk_i);
        address_o   <= a;
        read_o      <= ~wr;
        write_o     <= wr;
        writedata_o <= d;
        @(posedge clk_i);
        while (waitrequest_i !== 1'b0) @(posedge clk_i);
        q = readdata_i;
        read_o      <= 1'b0;
        write_o     <= 1'b0;
        // released lines change so a stale value cannot pass for a live one
        address_o   <= ~a;
        writedata_o <= ~d;
    endtask
endmodule // pim_host

// file: verif/pwm_input_measurement_bench.sv
// self-checking bench for the pulse-input measurement block
`timescale 1ns/1ps
`include "pwmim_regs.vh"
module pwm_input_measurement_bench;
    logic         clk_i   = 1'b0;
    logic         reset_i = 1'b1;
    logic [23:0]  in_i    = 24'h0;
    logic [10:0]  address;
    logic         read;
    logic         write;
    logic [31:0]  wdata;
    logic [31:0]  rdata;
    logic         waitreq;
    logic [287:0] thr_lo;
    logic [287:0] thr_hi;
    logic         led;
    logic [31:0]  ex [24];
    logic [31:0]  q;
    logic [31:0]  t0;
    logic         ce         = 1'b1;
    int           num_errors = 0;
    int           compares   = 0;

    always #4 clk_i = ~clk_i;

    pim_host host (.clk_i(clk_i), .waitrequest_i(waitreq), .readdata_i(rdata),
                   .address_o(address), .read_o(read), .write_o(write), .writedata_o(wdata));

    pwmim_top dut (.clk_i(clk_i), .reset_i(reset_i), .ce_i(ce), .avs_address_i(address),
                   .avs_read_i(read), .avs_write_i(write), .avs_writedata_i(wdata),
                   .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq), .in_i(in_i),
                   .battery_reference_a_i(12'h900), .battery_reference_b_i(12'h600),
                   .thr_lo_o(thr_lo), .thr_hi_o(thr_hi), .indicator_drive_o(led));

    function automatic logic [10:0] adr(input logic [3:0] k, input int s);
        return {k[2:0], 6'(s), 2'b00};
    endfunction

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic rd_chk(input logic [10:0] a, input logic [31:0] exp);
        host.xfer(1'b0, a, 32'h0, q);
        check(q, exp);
    endtask

    task automatic wr(input logic [10:0] a, input logic [31:0] d);
        host.xfer(1'b1, a, d, q);
    endtask

    // each slot set up here watches channel 3 with a zero timeout interval
    task automatic setup(input int s, input logic [3:0] p, input logic [1:0] tm,
                         input logic [31:0] e);
        wr(adr(`PWMIM_A_CFG, s), {16'h0, 3'h0, 5'h03, 2'h0, tm, p});
        ex[s] = e;
    endtask

    task automatic acquire;
        wr(`PWMIM_A_CTRL, 32'h1);
        repeat (3) @(posedge clk_i);
    endtask

    task complete_run;
        $display("comparisons %0d, mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial begin
        foreach (ex[i]) ex[i] = 32'h0;
        repeat (4) @(posedge clk_i);
        reset_i <= 1'b0;
        rd_chk(adr(`PWMIM_A_CFG, 0), `PWMIM_CFG_RST);
        rd_chk(adr(`PWMIM_A_DEF, 0), `PWMIM_DEF_RST);
        rd_chk(adr(`PWMIM_A_RES, 23), 32'h0);
        rd_chk(11'h7FC, 32'h0);
        rd_chk(`PWMIM_A_CTRL, 32'h0);
        check({8'h0, thr_hi[11:0], thr_lo[11:0]}, 32'h00600300);
        wr(adr(`PWMIM_A_THR, 5), {30'h0, `PWMIM_TSRC_B});
        wr(adr(`PWMIM_A_THR, 6), 32'h01230002);
        repeat (2) @(posedge clk_i);
        check({8'h0, thr_hi[71:60], thr_lo[71:60]}, 32'h00400200);
        check({8'h0, thr_hi[83:72], thr_lo[83:72]}, 32'h00246123);
        // five enabled clocks of 8 ns between the two samples are two ticks; frozen ones add none
        host.xfer(1'b0, `PWMIM_A_TIME, 32'h0, t0);
        ce <= 1'b0;
        repeat (5) @(posedge clk_i);
        ce <= 1'b1;
        repeat (2) @(posedge clk_i);
        host.xfer(1'b0, `PWMIM_A_TIME, 32'h0, q);
        check(q - t0, 32'h2);
        $display("reset values and thresholds done");

        wr(adr(`PWMIM_A_DEF, 13), 32'hA5A50013);
        setup(0, `PWMIM_P_HIGH, `PWMIM_TM_OFF, 32'h6);
        setup(1, `PWMIM_P_LOW, `PWMIM_TM_OFF, 32'h2);
        setup(2, `PWMIM_P_ADDHI, `PWMIM_TM_OFF, 32'h12);
        setup(3, `PWMIM_P_NLOP, `PWMIM_TM_OFF, 32'h3);
        setup(4, `PWMIM_P_NHIP, `PWMIM_TM_OFF, 32'h3);
        setup(5, `PWMIM_P_NRISE, `PWMIM_TM_OFF, 32'h3);
        setup(6, `PWMIM_P_NFALL, `PWMIM_TM_OFF, 32'h3);
        setup(7, `PWMIM_P_CYCLE, `PWMIM_TM_OFF, 32'h8);
        setup(8, `PWMIM_P_FREQ, `PWMIM_TM_OFF, 32'h005F5E10);
        setup(9, `PWMIM_P_DUTYL, `PWMIM_TM_OFF, 32'h4000);
        setup(10, `PWMIM_P_DUTYH, `PWMIM_TM_OFF, 32'hC000);
        setup(11, `PWMIM_P_LVLHI, `PWMIM_TM_OFF, 32'h0);
        setup(12, `PWMIM_P_LVLLO, `PWMIM_TM_OFF, 32'h1);
        setup(13, `PWMIM_P_HIGH, `PWMIM_TM_PREDEF, 32'hA5A50013);
        setup(14, `PWMIM_P_NRISE, `PWMIM_TM_INPDEP, 32'h0);
        setup(15, `PWMIM_P_DUTYL, `PWMIM_TM_INPDEP, `PWMIM_DUTY_ONE);
        setup(16, `PWMIM_P_DUTYH, `PWMIM_TM_INPDEP, 32'h0);
        // a 1 ms interval must not expire during the short pulse train
        wr(adr(`PWMIM_A_CFG, 17), {16'h0001, 8'h03, 2'h0, `PWMIM_TM_PREDEF, `PWMIM_P_HIGH});
        ex[17] = 32'h6;
        setup(23, `PWMIM_P_HIGH, `PWMIM_TM_OFF, 32'h6);
        acquire();
        // 15 clocks high is 6 ticks, 5 clocks low is 2 ticks
        repeat (3) begin
            in_i[3] <= 1'b1;
            repeat (15) @(posedge clk_i);
            in_i[3] <= 1'b0;
            repeat (5) @(posedge clk_i);
        end
        // leaves the frequency divider time to settle
        repeat (60) @(posedge clk_i);
        acquire();
        for (int s = 0; s < 24; s++) rd_chk(adr(`PWMIM_A_RES, s), ex[s]);
        $display("measurement procedures done");

        setup(0, `PWMIM_P_LOW, `PWMIM_TM_OFF, 32'h2);
        acquire();
        rd_chk(adr(`PWMIM_A_RES, 0), 32'h2);
        rd_chk(adr(`PWMIM_A_RES, 5), 32'h0);
        rd_chk(adr(`PWMIM_A_RES, 2), 32'h0);
        $display("reconfiguration and window restart done");

        wr(`PWMIM_A_LED, 32'h00000043);
        in_i[3] <= 1'b1;
        repeat (3) @(posedge clk_i);
        check({31'h0, led}, 32'h1);
        in_i[3] <= 1'b0;
        repeat (3) @(posedge clk_i);
        check({31'h0, led}, 32'h0);
        wr(`PWMIM_A_LED, 32'h00000020);
        repeat (3) @(posedge clk_i);
        check({31'h0, led}, 32'h1);
        $display("indicator source done");
        complete_run();
    end

    // the whole sequence needs well under 5000 cycles
    initial begin
        repeat (20000) @(posedge clk_i);
        num_errors++;
        $display("watchdog expired");
        complete_run();
    end
endmodule // pwm_input_measurement_bench
